// ### pts_defs.vh
// Purpose: constants for the programmable threshold stage
// Assumes: 25 MHz reference clock, fixed-point settings scaled by 10000, hysteresis by 1000000
// Notes: times in microseconds, derived counts in clock cycles (tick) and ticks (change window)
`ifndef PTS_DEFS_VH
`define PTS_DEFS_VH

`define PTS_CLK_HZ 25000000
`define PTS_TICK_US 5000
`define PTS_TICK_CYC ((`PTS_TICK_US * (`PTS_CLK_HZ / 1000000)))
`define PTS_DELTA_US 20000
`define PTS_DELTA_TICKS (`PTS_DELTA_US / `PTS_TICK_US)
`define PTS_DELAY_MAX 19'h57e40
`define PTS_OP_DLY_DEF 19'h00008
`define PTS_REL_DLY_DEF 19'h0000c
`define PTS_PICKUP_DEF 32'h00000064
`define PTS_HYST_DEF 20'h07530
`define PTS_HYST_SCALE 1000000
`define PTS_FIX_SCALE 10000

`define PTS_MODE_OVER 3'h0
`define PTS_MODE_OVER_ABS 3'h1
`define PTS_MODE_UNDER 3'h2
`define PTS_MODE_UNDER_ABS 3'h3
`define PTS_MODE_DPCT_DIR 3'h4
`define PTS_MODE_DPCT_ABS 3'h5
`define PTS_MODE_DVAL_DIR 3'h6
`define PTS_MODE_DVAL_ABS 3'h7

`define PTS_COND_NORMAL 2'h0
`define PTS_COND_START 2'h1
`define PTS_COND_TRIP 2'h2
`define PTS_COND_BLOCKED 2'h3

`define PTS_LN_ON 3'h1
`define PTS_LN_BLOCKED 3'h2
`define PTS_LN_TEST 3'h3
`define PTS_LN_TEST_BLK 3'h4
`define PTS_LN_OFF 3'h5

`endif

// ### pts_comparator.v
// Purpose: one magnitude comparison with hysteresis and 20 ms change detection
// Assumes: values are signed fixed point, scaled by 10000
// Notes: evaluated on each tick pulse; ratio is value/pickup scaled by 10000
`timescale 1ns/1ps
`include "pts_defs.vh"

module pts_comparator #(
  parameter W = 32
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // evaluation
  input wire i_tick,
  input wire [2:0] i_mode,
  input wire signed [W-1:0] i_measured_magnitude,
  input wire signed [W-1:0] i_pickup_level_value,
  input wire [19:0] i_hyst,
  input wire signed [W-1:0] i_block_limit,
  // results
  output reg o_pick,
  output reg signed [W-1:0] o_ratio
);

  localparam DN = `PTS_DELTA_TICKS;

  reg signed [W-1:0] hist [0:DN-1];
  reg signed [W-1:0] next_ratio;
  reg next_pick;
  reg signed [W-1:0] mag;
  reg signed [W-1:0] old;
  reg signed [W-1:0] diff;
  reg signed [W+23:0] band;
  reg signed [W+23:0] thr_on;
  reg signed [W+23:0] thr_off;
  reg signed [W+23:0] lhs;
  reg signed [W+23:0] ratio_w;
  integer k;

  function signed [W-1:0] f_abs;
    input signed [W-1:0] v;
    begin
      f_abs = v[W-1] ? -v : v;
    end
  endfunction

  always @* begin
    mag = i_measured_magnitude;
    old = hist[DN-1];
    diff = mag - old;
    band = ($signed({{24{i_pickup_level_value[W-1]}}, i_pickup_level_value})
      * $signed({{(W+4){1'b0}}, i_hyst})) / `PTS_HYST_SCALE;
    band = (band < 0) ? -band : band;
    thr_on = {{24{i_pickup_level_value[W-1]}}, i_pickup_level_value};
    thr_off = thr_on;
    lhs = {{24{mag[W-1]}}, mag};
    next_pick = 1'b0;
    case (i_mode)
      `PTS_MODE_OVER, `PTS_MODE_OVER_ABS: begin
        if (i_mode == `PTS_MODE_OVER_ABS)
          lhs = {{24{1'b0}}, f_abs(mag)};
        thr_off = thr_on - band;
        next_pick = o_pick ? (lhs > thr_off) : (lhs > thr_on);
      end
      `PTS_MODE_UNDER, `PTS_MODE_UNDER_ABS: begin
        if (i_mode == `PTS_MODE_UNDER_ABS)
          lhs = {{24{1'b0}}, f_abs(mag)};
        thr_off = thr_on + band;
        next_pick = (mag >= i_block_limit) &&
          (o_pick ? (lhs < thr_off) : (lhs < thr_on));
      end
      `PTS_MODE_DPCT_DIR, `PTS_MODE_DPCT_ABS: begin
        // relative change: diff*10000*100 vs pickup percent times |old|
        lhs = {{24{diff[W-1]}}, diff} * `PTS_FIX_SCALE * 100;
        thr_on = thr_on * {{24{1'b0}}, f_abs(old)};
        if (i_mode == `PTS_MODE_DPCT_ABS)
          next_pick = (lhs < 0 ? -lhs : lhs) > (thr_on < 0 ? -thr_on : thr_on);
        else if (thr_on < 0)
          next_pick = lhs < thr_on;
        else
          next_pick = lhs > thr_on;
      end
      `PTS_MODE_DVAL_DIR: begin
        lhs = {{24{diff[W-1]}}, diff};
        next_pick = (thr_on < 0) ? (lhs < thr_on) : (lhs > thr_on);
      end
      `PTS_MODE_DVAL_ABS: begin
        lhs = {{24{1'b0}}, f_abs(diff)};
        next_pick = lhs > (thr_on < 0 ? -thr_on : thr_on);
      end
      default: next_pick = 1'b0;
    endcase
    ratio_w = {(W+24){1'b0}};
    if (i_pickup_level_value != {W{1'b0}})
      ratio_w = ($signed({{24{mag[W-1]}}, mag}) * `PTS_FIX_SCALE)
        / $signed({{24{i_pickup_level_value[W-1]}}, i_pickup_level_value});
    next_ratio = ratio_w[W-1:0];
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pick <= 1'b0;
      o_ratio <= {W{1'b0}};
      for (k = 0; k < DN; k = k + 1)
        hist[k] <= {W{1'b0}};
    end else if (i_tick) begin
      o_pick <= next_pick;
      o_ratio <= next_ratio;
      hist[0] <= mag;
      for (k = 1; k < DN; k = k + 1)
        hist[k] <= hist[k-1];
    end
  end

endmodule // pts_comparator

// ### pts_stage.v
// Purpose: programmable threshold stage with start, trip and blocked outputs
// Assumes: measurements scaled upstream, settings held stable by the host
// Notes: one evaluation per 5 ms tick; delays counted in ticks
`timescale 1ns/1ps
`include "pts_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - condition code: 0 normal, 1 started, 2 tripped, 3 blocked
// - node mode code: 1 on, 2 blocked, 3 test, 4 test/blocked, 5 off
// - remaining time to trip shown while timing, 0 to 1800 s
// - ratio of measured magnitude to pick-up level computed whenever the pick-up level is nonzero (else 0) and readable
// - each comparison has own relative hysteresis, default 3 percent
// - each comparison has an eight-value mode field, default greater-than
// - signed pick-up levels per comparison, resolution 0.0001, default 0.01
// - operate delay 0 to 1800 s in 5 ms steps, default 40 ms
// - release delay same range and step, default 60 ms
// - mode 0 signed over, mode 1 absolute over
// - mode 2 signed under, mode 3 absolute under
// - under modes inhibited while measurement below blocking limit
// - mode 4 relative change in 20 ms, direction dependent
// - mode 5 relative change in 20 ms, either direction
// - mode 6 change in units in 20 ms, direction dependent
// - mode 7 change in units in 20 ms, either direction
// - block input sampled at start of each evaluation cycle
// - pick-up without block asserts start and begins operate timing
// - pick-up with block asserts blocked, no start or trip
// - block after start clears start and operate timing; release timing runs only once tripped
// - entering blocked issues event with captured values and fault type
// - separate on and off events for start, trip and blocked
module pts_stage #(
  parameter W = 32,
  parameter TICK_CYC = `PTS_TICK_CYC
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_sys_rst,
  // measurements, three plus derived
  input wire [4*W-1:0] i_measured_magnitude,
  input wire [3:0] i_cmp_enable,
  // per comparison settings
  input wire [11:0] i_mode,
  input wire [4*W-1:0] i_pickup_level_value,
  input wire [79:0] i_hyst,
  input wire [4*W-1:0] i_block_limit,
  // stage settings
  input wire [18:0] i_op_delay,
  input wire [18:0] i_rel_delay,
  input wire [2:0] i_logical_node_mode,
  // external block, pin from blocking matrix
  input wire i_block,
  // status
  output reg o_start,
  output reg o_trip,
  output reg o_blocked,
  output reg [1:0] o_condition,
  output reg [2:0] o_logical_node_mode,
  output reg [18:0] o_trip_remaining,
  output reg [4*W-1:0] o_ratio,
  // events
  output reg [5:0] o_event,
  output reg signed [W-1:0] o_event_value,
  output reg [1:0] o_event_fault
);

  localparam DW = $clog2(TICK_CYC + 1);

  reg [DW-1:0] div;
  reg tick;
  reg blk_s1;
  reg blk_s2;
  wire [3:0] pick_v;
  wire [4*W-1:0] ratio_v;
  reg pick_any;
  reg [1:0] first_idx;
  reg [18:0] op_cnt;
  reg [18:0] rel_cnt;
  reg next_start;
  reg next_trip;
  reg next_blocked;
  reg stage_off;
  reg stage_blk;
  integer j;

  ////////////////////////////////////////////////////////////////////////////
  // 5 ms evaluation tick
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      div <= {DW{1'b0}};
      tick <= 1'b0;
    end else if (div == TICK_CYC - 1) begin
      div <= {DW{1'b0}};
      tick <= 1'b1;
    end else begin
      div <= div + 1'b1;
      tick <= 1'b0;
    end
  end

  // block pin synchroniser, then sampled once per cycle
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
    end else begin
      blk_s1 <= i_block;
      blk_s2 <= blk_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparators
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cmp
      pts_comparator #(.W(W)) u_cmp (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_tick(tick),
        .i_mode(i_mode[3*g +: 3]),
        .i_measured_magnitude(i_measured_magnitude[W*g +: W]),
        .i_pickup_level_value(i_pickup_level_value[W*g +: W]),
        .i_hyst(i_hyst[20*g +: 20]),
        .i_block_limit(i_block_limit[W*g +: W]),
        .o_pick(pick_v[g]),
        .o_ratio(ratio_v[W*g +: W])
      );
    end
  endgenerate

  always @* begin
    pick_any = 1'b0;
    first_idx = 2'h0;
    for (j = 3; j >= 0; j = j - 1) begin
      if (pick_v[j] && i_cmp_enable[j]) begin
        pick_any = 1'b1;
        first_idx = j[1:0];
      end
    end
    stage_off = (i_logical_node_mode == `PTS_LN_OFF);
    stage_blk = (i_logical_node_mode == `PTS_LN_BLOCKED) ||
      (i_logical_node_mode == `PTS_LN_TEST_BLK);
  end

  ////////////////////////////////////////////////////////////////////////////
  // start, trip and blocked sequencing
  always @* begin
    next_start = o_start;
    next_trip = o_trip;
    next_blocked = o_blocked;
    if (stage_off) begin
      next_start = 1'b0;
      next_trip = 1'b0;
      next_blocked = 1'b0;
    // block taken as it stands at the tick, so it costs at most one tick
    end else if (pick_any && (blk_s2 || stage_blk)) begin
      next_blocked = 1'b1;
      next_start = 1'b0;
    end else if (pick_any) begin
      next_blocked = 1'b0;
      next_start = 1'b1;
      if (o_start && op_cnt >= i_op_delay)
        next_trip = 1'b1;
    end else begin
      next_blocked = 1'b0;
      next_start = 1'b0;
    end
    if (!next_start && o_trip && rel_cnt >= i_rel_delay)
      next_trip = 1'b0;
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_start <= 1'b0;
      o_trip <= 1'b0;
      o_blocked <= 1'b0;
      op_cnt <= 19'h0;
      rel_cnt <= 19'h0;
      o_event <= 6'h0;
      o_event_value <= {W{1'b0}};
      o_event_fault <= 2'h0;
    end else begin
      o_event <= 6'h0;
      if (tick) begin
        o_start <= next_start;
        o_trip <= next_trip;
        o_blocked <= next_blocked;
        if (next_start && op_cnt != `PTS_DELAY_MAX)
          op_cnt <= o_start ? op_cnt + 1'b1 : 19'h1;
        else if (!next_start)
          op_cnt <= 19'h0;
        if (!next_start && o_trip)
          rel_cnt <= rel_cnt + 1'b1;
        else
          rel_cnt <= 19'h0;
        // on/off pairs: start, trip, blocked
        o_event <= {o_blocked & ~next_blocked, ~o_blocked & next_blocked,
          o_trip & ~next_trip, ~o_trip & next_trip,
          o_start & ~next_start, ~o_start & next_start};
        if (~o_blocked & next_blocked) begin
          o_event_value <= i_measured_magnitude[W*first_idx +: W];
          o_event_fault <= first_idx;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display status
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_condition <= `PTS_COND_NORMAL;
      o_logical_node_mode <= `PTS_LN_ON;
      o_trip_remaining <= 19'h0;
      o_ratio <= {4*W{1'b0}};
    end else begin
      o_ratio <= ratio_v;
      o_logical_node_mode <= i_logical_node_mode;
      if (o_blocked)
        o_condition <= `PTS_COND_BLOCKED;
      else if (o_trip)
        o_condition <= `PTS_COND_TRIP;
      else if (o_start)
        o_condition <= `PTS_COND_START;
      else
        o_condition <= `PTS_COND_NORMAL;
      // op_cnt is already 1 on the tick that raises start
      if (o_start && !o_trip && i_op_delay >= op_cnt)
        o_trip_remaining <= i_op_delay - op_cnt + 19'h1;
      else
        o_trip_remaining <= 19'h0;
    end
  end

endmodule // pts_stage

// ### pts_stage_props.sv
// Purpose: port checker for the threshold stage
// Assumes: one clock, asynchronous active-high reset
// Notes: attached to every stage instance by bind
`timescale 1ns/1ps
`include "pts_defs.vh"

module pts_stage_props #(
  parameter TICK_CYC = 10
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire [18:0] i_op_delay,
  input wire o_start,
  input wire o_trip,
  input wire o_blocked,
  input wire [1:0] o_condition,
  input wire [5:0] o_event
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  reg [31:0] start_len;
  // cycles of continuous start
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) start_len <= 32'h0;
    else if (o_start) start_len <= start_len + 32'h1;
    else start_len <= 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_trip_full_delay: assert property ($rose(o_trip) |->
    start_len >= i_op_delay * TICK_CYC)
    else $error("trip before operate delay");
  a_trip_from_start: assert property ($rose(o_trip) |-> $past(o_start))
    else $error("trip without start");
  a_block_no_start: assert property (o_blocked |-> !o_start)
    else $error("start while blocked");
  a_cond_blocked: assert property (o_blocked |=>
    o_condition == `PTS_COND_BLOCKED)
    else $error("condition not blocked");
  a_cond_trip: assert property (o_trip && !o_blocked |=>
    o_condition == `PTS_COND_TRIP)
    else $error("condition not trip");
  a_cond_normal: assert property (!o_start && !o_trip && !o_blocked |=>
    o_condition == 2'h0)
    else $error("condition not normal");
  a_start_on_event: assert property ($rose(o_start) |->
    o_event[0] && !$past(o_event[0]))
    else $error("missing start on event");
  a_start_off_event: assert property ($fell(o_start) |-> o_event[1])
    else $error("missing start off event");
  a_trip_events: assert property ($changed(o_trip) |->
    o_event[2] == o_trip && o_event[3] != o_trip)
    else $error("wrong trip event");
  a_block_on_event: assert property ($rose(o_blocked) |-> o_event[4])
    else $error("missing blocked on event");
endmodule // pts_stage_props

bind pts_stage pts_stage_props #(.TICK_CYC(TICK_CYC)) u_props (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_op_delay(i_op_delay), .o_start(o_start), .o_trip(o_trip),
  .o_blocked(o_blocked), .o_condition(o_condition), .o_event(o_event));

// ### pts_meas_source.sv
// Purpose: measurement chain and blocking matrix model
// Assumes: one measurement on slot 0, others held at zero
// Notes: requests take effect one clock later
`timescale 1ns/1ps

module pts_meas_source (
  // clock
  input wire i_ref_clk,
  // requests
  input wire signed [31:0] i_level,
  input wire i_blk_req,
  // to the stage
  output reg [127:0] o_measured_magnitude,
  output reg o_block
);
  always @(posedge i_ref_clk) begin
    o_measured_magnitude <= {96'h0, i_level};
    o_block <= i_blk_req;
  end
endmodule // pts_meas_source

// ### pts_stage_bench.sv
// Purpose: self-checking bench for the threshold stage
// Assumes: short tick of 10 clocks, operate delay 2, release 3
// Notes: each case restarts the stage to clear change history
`timescale 1ns/1ps
`include "pts_defs.vh"

module pts_stage_bench;
  localparam TICK = 10;
  reg clk, rst, blk_req;
  reg signed [31:0] level;
  reg [11:0] mode;
  reg [127:0] pickup, limit;
  reg [18:0] op_dly;
  reg [2:0] ln_mode;
  wire [18:0] rem;
  integer err_count, tests_run, cycles;
  wire [127:0] meas, ratio;
  wire blk_pin, start, trip, blocked;
  wire [1:0] cond, ev_fault;
  wire [2:0] ln;
  wire [5:0] ev;
  wire signed [31:0] ev_val;
  pts_meas_source model (.i_ref_clk(clk), .i_level(level), .i_blk_req(blk_req),
    .o_measured_magnitude(meas), .o_block(blk_pin));
  pts_stage #(.TICK_CYC(TICK)) dut (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_measured_magnitude(meas), .i_cmp_enable(4'h1), .i_mode(mode), .i_pickup_level_value(pickup),
    .i_hyst({4{`PTS_HYST_DEF}}), .i_block_limit(limit), .i_op_delay(op_dly),
    .i_rel_delay(19'h00003), .i_logical_node_mode(ln_mode), .i_block(blk_pin),
    .o_start(start), .o_trip(trip), .o_blocked(blocked), .o_condition(cond),
    .o_logical_node_mode(ln), .o_trip_remaining(rem), .o_ratio(ratio), .o_event(ev),
    .o_event_value(ev_val), .o_event_fault(ev_fault));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task stop_test;
    begin
      $display("comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task do_reset;
    begin
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
    end
  endtask
  // or of start, trip and blocked over n cycles
  task watch(input integer n, output reg s, output reg t, output reg b);
    begin
      {s, t, b} = 3'h0;
      repeat (n) begin
        @(negedge clk);
        s = s | (start === 1'b1);
        t = t | (trip === 1'b1);
        b = b | (blocked === 1'b1);
      end
    end
  endtask
  task run_case(input [2:0] m, input [31:0] pk, input [31:0] b, input [31:0] s,
                input [31:0] lim, input e);
    reg st, tr, bl;
    begin
      @(posedge clk);
      mode <= {9'h0, m};
      pickup <= {96'h0, pk};
      limit <= {96'h0, lim};
      level <= b;
      do_reset;
      // change history restarts at zero, so let a false delta start die out
      repeat (10 * TICK) @(posedge clk);
      level <= s;
      watch(8 * TICK, st, tr, bl);
      check(32'(st), 32'(e));
    end
  endtask
  task over_trip;
    reg st, tr, bl;
    begin
      @(posedge clk);
      mode <= 12'h0;
      pickup <= 128'h64;
      level <= 0;
      do_reset;
      @(negedge clk);
      check(32'(cond), 32'h0);
      check(32'(ln), 32'h1);
      @(posedge clk);
      level <= 32'sd200;
      watch(2 * TICK + 3, st, tr, bl);
      check(32'(st), 32'h1);
      check(32'(cond), 32'h1);
      check(ratio[31:0], 32'd20000);
      check(32'(rem), 32'(op_dly));
      watch(4 * TICK, st, tr, bl);
      check(32'(trip), 32'h1);
      check(32'(cond), 32'h2);
      check(32'(rem), 32'h0);
      // 98 lies inside the 3 percent release band below 100
      @(posedge clk);
      level <= 32'sd98;
      repeat (3 * TICK) @(negedge clk);
      check(32'(start), 32'h1);
      @(posedge clk);
      level <= 0;
      repeat (3 * TICK) @(negedge clk);
      check(32'(trip), 32'h1);
      repeat (3 * TICK) @(negedge clk);
      check(32'({start, trip}), 32'h0);
    end
  endtask
  task blocked_pick;
    reg st, tr, bl;
    begin
      @(posedge clk);
      blk_req <= 1'b1;
      level <= 0;
      do_reset;
      repeat (3 * TICK) @(posedge clk);
      level <= 32'sd300;
      watch(6 * TICK, st, tr, bl);
      check(32'({st, tr, bl}), 32'h1);
      check(32'(cond), 32'h3);
      check(ev_val, 32'd300);
      check(32'(ev_fault), 32'h0);
      @(posedge clk);
      blk_req <= 1'b0;
    end
  endtask
  task block_after_start;
    reg st, tr, bl;
    begin
      @(posedge clk);
      op_dly <= 19'h00014;
      level <= 32'sd200;
      do_reset;
      watch(3 * TICK, st, tr, bl);
      check(32'(start), 32'h1);
      @(posedge clk);
      blk_req <= 1'b1;
      watch(5 * TICK, st, tr, bl);
      check(32'({start, tr}), 32'h0);
      @(posedge clk);
      blk_req <= 1'b0;
      op_dly <= 19'h00002;
    end
  endtask
  task node_modes;
    reg st, tr, bl;
    begin
      @(posedge clk);
      level <= 32'sd200;
      ln_mode <= `PTS_LN_OFF;
      do_reset;
      watch(4 * TICK, st, tr, bl);
      check(32'({st, tr, bl}), 32'h0);
      check(32'(ln), 32'h5);
      @(posedge clk);
      ln_mode <= `PTS_LN_BLOCKED;
      watch(3 * TICK, st, tr, bl);
      check(32'({st, blocked}), 32'h1);
      check(32'(ln), 32'h2);
      @(posedge clk);
      ln_mode <= `PTS_LN_TEST_BLK;
      watch(2 * TICK, st, tr, bl);
      check(32'({st, blocked}), 32'h1);
      check(32'(ln), 32'h4);
      @(posedge clk);
      ln_mode <= `PTS_LN_ON;
    end
  endtask
  initial begin
    {blk_req, err_count, tests_run, cycles} = 0;
    rst = 1'b1;
    ln_mode = `PTS_LN_ON;
    level = 0;
    mode = 12'h0;
    pickup = 128'h64;
    limit = 128'h0;
    op_dly = 19'h00002;
    over_trip;
    blocked_pick;
    block_after_start;
    node_modes;
    run_case(3'h0, 100, 200, 200, 0, 1'b1);
    run_case(3'h0, 100, -200, -200, 0, 1'b0);
    run_case(3'h1, 100, -200, -200, 0, 1'b1);
    run_case(3'h2, 100, 50, 50, 0, 1'b1);
    run_case(3'h2, 100, 50, 50, 60, 1'b0);
    run_case(3'h3, 100, -50, -50, -1000, 1'b1);
    run_case(3'h3, 100, -300, -300, -1000, 1'b0);
    run_case(3'h4, 100000, 10000, 20000, 0, 1'b1);
    run_case(3'h4, 100000, 10000, 5000, 0, 1'b0);
    run_case(3'h5, 100000, 10000, 5000, 0, 1'b1);
    run_case(3'h6, 100, 2000, 1000, 0, 1'b0);
    run_case(3'h6, 100, 1000, 2000, 0, 1'b1);
    run_case(3'h7, 100, 2000, 1000, 0, 1'b1);
    stop_test;
  end
endmodule // pts_stage_bench
